//--- dbp_bus_model.sv
/*
 * Transceiver model of the diagnostic buses as seen from the receive pins.
 * Assumes active-high drives and no delay through the bus.
 */
`timescale 1ns/1ps

module dbp_bus_model (
    // Line drives from the device
    input wire logic i_pos_drive,
    input wire logic i_k_drive,
    // Other nodes pulling the buses dominant
    input wire logic i_node_vpw,
    input wire logic i_node_iso,
    input wire logic i_node_pwm,
    // Receive pins of the device
    output logic o_vpw_rx,
    output logic o_iso_rx_n,
    output logic o_pwm_rx_n
);
    // Released buses fall back to their recessive idle level
    assign o_vpw_rx = i_pos_drive | i_node_vpw;
    assign o_iso_rx_n = !(i_k_drive | i_node_iso);
    assign o_pwm_rx_n = !(i_pos_drive | i_node_pwm);
endmodule : dbp_bus_model

//--- dbp_defines.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * diagnostic-bridge pin front end.
 * Assumes a 200 MHz core clock and a byte-addressed 32-bit register port.
 */
`ifndef DBP_DEFINES_SVH
`define DBP_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses)
`define DBP_ADDR_W 8
`define DBP_OFS_CTRL 8'h00
`define DBP_OFS_CMD 8'h04
`define DBP_OFS_DRIVE 8'h08
`define DBP_OFS_STATUS 8'h0C

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define DBP_CTRL_PROTO_LSB 0
`define DBP_CTRL_SUPPLY_POL 2
`define DBP_CTRL_BAUD_OVR_EN 3
`define DBP_CTRL_STANDBY 4
`define DBP_CTRL_BAUD_OVR_LSB 8

// Drive register fields
`define DBP_DRV_POS 0
`define DBP_DRV_NEG 1
`define DBP_DRV_K 2
`define DBP_DRV_L 3

// Status register fields
`define DBP_ST_VPW 0
`define DBP_ST_ISO 1
`define DBP_ST_PWM 2
`define DBP_ST_MEM 3
`define DBP_ST_LF 4
`define DBP_ST_BAUD_LSB 5
`define DBP_ST_RUN 7

////////////////////////////////////////////////////////////////////////////////
// Synchronised pin vector positions
`define DBP_PIN_W 7
`define DBP_PIN_EXT_RST 0
`define DBP_PIN_MEM 1
`define DBP_PIN_BAUD 2
`define DBP_PIN_LF 3
`define DBP_PIN_VPW 4
`define DBP_PIN_ISO 5
`define DBP_PIN_PWM 6

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define DBP_RST_BAUD_OVR 8'h00
`define DBP_RST_DRIVE 4'h0

////////////////////////////////////////////////////////////////////////////////
// Timing
`define DBP_CLK_MHZ 200
`define DBP_EXT_RST_MIN_NS 2000
`define DBP_EXT_RST_CYCLES ((`DBP_EXT_RST_MIN_NS * `DBP_CLK_MHZ + 999) / 1000)
`define DBP_SYNC_STAGES 2
`define DBP_CNT_W 9

`endif

//--- dbp_pkg.sv
/*
 * Types of the diagnostic-bridge pin front end.
 * Assumes dbp_defines.svh is on the include path.
 */
`include "dbp_defines.svh"

package dbp_pkg;

    typedef enum logic [1:0] {
        DBP_PROTO_VPW = 2'h0,
        DBP_PROTO_PWM = 2'h1,
        DBP_PROTO_ISO = 2'h2
    } dbp_proto_t;

    typedef enum logic [1:0] {
        DBP_CMD_MEM_OFF = 2'h0,
        DBP_CMD_MEM_ON = 2'h1,
        DBP_CMD_LF_OFF = 2'h2,
        DBP_CMD_LF_ON = 2'h3
    } dbp_cmd_t;

    typedef enum logic [1:0] {
        DBP_BAUD_9600 = 2'h0,
        DBP_BAUD_38400 = 2'h1,
        DBP_BAUD_OVERRIDE = 2'h2
    } dbp_baud_t;

    typedef enum logic [1:0] {
        DBP_LATCH_WAIT,
        DBP_RUN,
        DBP_EXT_RESET
    } dbp_state_t;

    typedef struct packed {
        logic pos;
        logic neg;
        logic k;
        logic l;
    } dbp_drive_t;

    typedef struct packed {
        dbp_state_t state;
        logic [`DBP_CNT_W-1:0] cnt;
        dbp_proto_t proto;
        logic supply_pol;
        logic baud_ovr_en;
        logic [7:0] baud_ovr;
        logic standby;
        logic baud_strap;
        logic mem_en;
        logic lf_en;
        logic [3:0] drive_req;
        dbp_drive_t drive;
        logic supply_sel;
        logic osc_en;
        dbp_baud_t baud_sel;
        logic vpw_act;
        logic iso_act;
        logic pwm_act;
        logic [31:0] rd_data;
    } dbp_st_t;

endpackage : dbp_pkg

//--- dbp_props.sv
/*
 * Checker of the diagnostic-bridge pin front end, bound into dbp_top.
 * Assumes registered outputs and a two-flop sync on every pin input.
 */
`timescale 1ns/1ps
`include "dbp_defines.svh"

module dbp_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Pins and register port
    input wire logic i_ext_reset_n,
    input wire logic i_variable_pulse_rx,
    input wire logic i_iso_rx_n,
    input wire logic i_pulse_width_rx_n,
    input wire logic [`DBP_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    // Observed outputs
    input wire logic o_bus_supply_select,
    input wire logic o_pos_line_drive,
    input wire logic o_neg_line_drive,
    input wire logic o_k_line_drive,
    input wire logic o_l_line_drive,
    input wire logic o_osc_enable,
    input wire logic o_mem_enable,
    input wire logic o_linefeed_enable,
    input wire logic o_vpw_active,
    input wire logic o_iso_active,
    input wire logic o_pwm_active,
    input wire logic o_running
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    logic [8:0] low_cnt_reg;
    logic live;
    logic ctrl_wr;
    logic drv_wr;
    logic cmd_wr;
    assign live = o_running && o_osc_enable;
    assign ctrl_wr = i_wr_en && o_running && i_addr == `DBP_OFS_CTRL;
    assign drv_wr = i_wr_en && live && i_addr == `DBP_OFS_DRIVE;
    assign cmd_wr = i_wr_en && o_running && i_addr == `DBP_OFS_CMD;

    // Consecutive low samples of the reset pin, saturating
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            low_cnt_reg <= 9'h000;
        end else if (i_ext_reset_n) begin
            low_cnt_reg <= 9'h000;
        end else if (low_cnt_reg != 9'h1FF) begin
            low_cnt_reg <= low_cnt_reg + 9'h001;
        end
    end

    ////////////////////////////////////////
    property p_ext; low_cnt_reg == 9'h1A4 |-> !o_running; endproperty
    a_ext: assert property (p_ext) else $error("long reset pulse ignored");
    property p_sup;
        ctrl_wr |=> o_bus_supply_select == (($past(i_wr_data[1:0]) == 2'h0) ^ $past(i_wr_data[2]));
    endproperty
    a_sup: assert property (p_sup) else $error("supply select wrong");
    property p_pos; drv_wr |=> o_pos_line_drive == $past(i_wr_data[0]); endproperty
    a_pos: assert property (p_pos) else $error("pos drive wrong");
    property p_idle;
        !o_running |-> !(o_pos_line_drive || o_neg_line_drive || o_k_line_drive || o_l_line_drive);
    endproperty
    a_idle: assert property (p_idle) else $error("drive while down");
    property p_neg; o_neg_line_drive |-> live; endproperty
    a_neg: assert property (p_neg) else $error("neg drive while idle");
    property p_mem; cmd_wr && !i_wr_data[1] |=> o_mem_enable == $past(i_wr_data[0]); endproperty
    a_mem: assert property (p_mem) else $error("memory command lost");
    property p_lf; cmd_wr && i_wr_data[1] |=> o_linefeed_enable == $past(i_wr_data[0]); endproperty
    a_lf: assert property (p_lf) else $error("linefeed command lost");
    property p_osc; ctrl_wr |=> o_osc_enable == !$past(i_wr_data[4]); endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    property p_vpw; live [*4] |-> o_vpw_active == $past(i_variable_pulse_rx, 3); endproperty
    a_vpw: assert property (p_vpw) else $error("vpw activity wrong");
    property p_iso; live [*4] |-> o_iso_active == !$past(i_iso_rx_n, 3); endproperty
    a_iso: assert property (p_iso) else $error("iso activity wrong");
    property p_pwm; live [*4] |-> o_pwm_active == !$past(i_pulse_width_rx_n, 3); endproperty
    a_pwm: assert property (p_pwm) else $error("pwm activity wrong");
    property p_kl;
        drv_wr |=> o_k_line_drive == $past(i_wr_data[2]) && o_l_line_drive == $past(i_wr_data[3]);
    endproperty
    a_kl: assert property (p_kl) else $error("iso drive wrong");
endmodule : dbp_props

bind dbp_top dbp_props u_props (.i_clk, .i_rst_b, .i_ext_reset_n, .i_variable_pulse_rx,
    .i_iso_rx_n, .i_pulse_width_rx_n, .i_addr, .i_wr_data, .i_wr_en, .o_bus_supply_select,
    .o_pos_line_drive, .o_neg_line_drive, .o_k_line_drive, .o_l_line_drive, .o_osc_enable,
    .o_mem_enable, .o_linefeed_enable, .o_vpw_active, .o_iso_active, .o_pwm_active, .o_running);

//--- dbp_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous pin inputs.
 * Assumes each bit is an independent level; no bit relation is kept.
 */
`timescale 1ns/1ps

module dbp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Pins and synchronised copy
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);

    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge i_clk or negedge i_rst_b) begin
                if (!i_rst_b) begin
                    meta_reg <= RST_VAL[g];
                    sync_reg <= RST_VAL[g];
                end else begin
                    meta_reg <= i_async[g];
                    sync_reg <= meta_reg;
                end
            end
            assign o_sync[g] = sync_reg;
        end
    endgenerate

endmodule : dbp_sync

//--- dbp_top.sv
/*
 * Pin front end of a vehicle-diagnostic to serial bridge: strap capture,
 * external reset filter, bus supply select, line drivers, receive inputs
 * and the crystal oscillator enable, with a small register port.
 * Assumes all pins are asynchronous to i_clk and that i_rst_b is the
 * power-on reset.
 */
// Our own choices: the register offsets and the plain strobed port.
// Summary of operation
// - A low on the external reset pin held for at least 2 us gives a full reset.
// - Bus supply select is high for VPW (8V) and low for PWM (5V), inverted by the supply_pol control register bit.
// - The positive line drive is high only while the positive bus line is forced active.
// - The negative line drive forces the negative line dominant and is used only for PWM.
// - The memory strap sampled at reset sets the default of the memory function.
// - Memory on and off commands override that default at any time while running; writes are ignored outside running.
// - The baud strap sets 38400 (or the override rate) when high and 9600 when low.
// - The line-end strap sets CR plus LF when high and CR alone when low.
// - Linefeed on and off commands override the line-end default at any time while running; writes are ignored outside running.
// - The crystal oscillator runs normally and is stopped in standby.
// - The VPW receive input is active high; low is the idle state.
// - The K-line receive input is active low; high is the idle state.
// - The PWM receive input is active low; high is the idle state.
// - K-line and L-line drive outputs are high to force dominant and low to release.
`timescale 1ns/1ps
`include "dbp_defines.svh"

module dbp_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Reset pin and straps
    input wire logic i_ext_reset_n,
    input wire logic i_memory_strap,
    input wire logic i_baud_strap,
    input wire logic i_line_end_strap,
    // Bus receive inputs
    input wire logic i_variable_pulse_rx,
    input wire logic i_iso_rx_n,
    input wire logic i_pulse_width_rx_n,
    // Register port
    input wire logic [`DBP_ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr_en,
    input wire logic i_rd_en,
    output logic [31:0] o_rd_data,
    // Bus drivers
    output logic o_bus_supply_select,
    output logic o_pos_line_drive,
    output logic o_neg_line_drive,
    output logic o_k_line_drive,
    output logic o_l_line_drive,
    // Oscillator and host settings
    output logic o_osc_enable,
    output dbp_pkg::dbp_baud_t o_baud_sel,
    output logic [7:0] o_baud_override,
    output logic o_mem_enable,
    output logic o_linefeed_enable,
    // Received bus activity and run state
    output logic o_vpw_active,
    output logic o_iso_active,
    output logic o_pwm_active,
    output logic o_running
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    localparam logic [`DBP_CNT_W-1:0] EXT_RST_CYC = `DBP_CNT_W'(`DBP_EXT_RST_CYCLES);
    localparam logic [`DBP_CNT_W-1:0] SYNC_CYC = `DBP_CNT_W'(`DBP_SYNC_STAGES);
    // Idle levels: reset pin high, VPW low, ISO and PWM high
    localparam logic [`DBP_PIN_W-1:0] PIN_IDLE = 7'h61;

    logic [`DBP_PIN_W-1:0] pins_async;
    logic [`DBP_PIN_W-1:0] pins;

    assign pins_async = {i_pulse_width_rx_n, i_iso_rx_n, i_variable_pulse_rx,
                         i_line_end_strap, i_baud_strap, i_memory_strap, i_ext_reset_n};

    dbp_sync #(
        .W(`DBP_PIN_W),
        .RST_VAL(PIN_IDLE)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(pins_async),
        .o_sync(pins)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic hit(input logic [`DBP_ADDR_W-1:0] a,
                                 input logic [`DBP_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic dbp_pkg::dbp_baud_t baud_of(input logic strap, input logic ovr_en);
        if (!strap) begin
            baud_of = dbp_pkg::DBP_BAUD_9600;
        end else if (ovr_en) begin
            baud_of = dbp_pkg::DBP_BAUD_OVERRIDE;
        end else begin
            baud_of = dbp_pkg::DBP_BAUD_38400;
        end
    endfunction : baud_of

    ////////////////////////////////////////////////////////////////////////////
    // State

    dbp_pkg::dbp_st_t st_reg;
    dbp_pkg::dbp_st_t st_next;

    localparam dbp_pkg::dbp_st_t ST_RST = '{
        state: dbp_pkg::DBP_LATCH_WAIT,
        cnt: '0,
        proto: dbp_pkg::DBP_PROTO_VPW,
        supply_pol: 1'b0,
        baud_ovr_en: 1'b0,
        baud_ovr: `DBP_RST_BAUD_OVR,
        standby: 1'b0,
        baud_strap: 1'b0,
        mem_en: 1'b0,
        lf_en: 1'b0,
        drive_req: `DBP_RST_DRIVE,
        drive: '0,
        supply_sel: 1'b1,
        osc_en: 1'b1,
        baud_sel: dbp_pkg::DBP_BAUD_9600,
        vpw_act: 1'b0,
        iso_act: 1'b0,
        pwm_act: 1'b0,
        rd_data: '0
    };

    logic run;
    logic wr_ok;

    assign run = (st_reg.state == dbp_pkg::DBP_RUN);
    assign wr_ok = i_wr_en && run;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        st_next = st_reg;
        st_next.rd_data = '0;

        // Reset pin filter and strap capture
        case (st_reg.state)
            dbp_pkg::DBP_LATCH_WAIT: begin
                // Wait until the strap samples have crossed the synchroniser
                if (st_reg.cnt >= SYNC_CYC) begin
                    st_next.state = dbp_pkg::DBP_RUN;
                    st_next.cnt = '0;
                    st_next.mem_en = pins[`DBP_PIN_MEM];
                    st_next.baud_strap = pins[`DBP_PIN_BAUD];
                    st_next.lf_en = pins[`DBP_PIN_LF];
                end else begin
                    st_next.cnt = st_reg.cnt + `DBP_CNT_W'(1);
                end
            end
            dbp_pkg::DBP_RUN: begin
                if (!pins[`DBP_PIN_EXT_RST]) begin
                    if (st_reg.cnt >= EXT_RST_CYC - `DBP_CNT_W'(1)) begin
                        st_next.state = dbp_pkg::DBP_EXT_RESET;
                        st_next.cnt = '0;
                    end else begin
                        st_next.cnt = st_reg.cnt + `DBP_CNT_W'(1);
                    end
                end else begin
                    st_next.cnt = '0;
                end
            end
            dbp_pkg::DBP_EXT_RESET: begin
                // Full reset of everything but the stored parameters
                st_next.proto = dbp_pkg::DBP_PROTO_VPW;
                st_next.standby = 1'b0;
                st_next.drive_req = `DBP_RST_DRIVE;
                st_next.mem_en = 1'b0;
                st_next.lf_en = 1'b0;
                st_next.baud_strap = 1'b0;
                st_next.cnt = '0;
                if (pins[`DBP_PIN_EXT_RST]) begin
                    st_next.state = dbp_pkg::DBP_LATCH_WAIT;
                end
            end
            default: begin
                st_next.state = dbp_pkg::DBP_LATCH_WAIT;
                st_next.cnt = '0;
            end
        endcase

        // Register writes
        if (wr_ok && hit(i_addr, `DBP_OFS_CTRL)) begin
            st_next.proto = dbp_pkg::dbp_proto_t'(i_wr_data[`DBP_CTRL_PROTO_LSB +: 2]);
            st_next.supply_pol = i_wr_data[`DBP_CTRL_SUPPLY_POL];
            st_next.baud_ovr_en = i_wr_data[`DBP_CTRL_BAUD_OVR_EN];
            st_next.standby = i_wr_data[`DBP_CTRL_STANDBY];
            st_next.baud_ovr = i_wr_data[`DBP_CTRL_BAUD_OVR_LSB +: 8];
        end
        if (wr_ok && hit(i_addr, `DBP_OFS_CMD)) begin
            case (dbp_pkg::dbp_cmd_t'(i_wr_data[1:0]))
                dbp_pkg::DBP_CMD_MEM_OFF: st_next.mem_en = 1'b0;
                dbp_pkg::DBP_CMD_MEM_ON: st_next.mem_en = 1'b1;
                dbp_pkg::DBP_CMD_LF_OFF: st_next.lf_en = 1'b0;
                dbp_pkg::DBP_CMD_LF_ON: st_next.lf_en = 1'b1;
                default: st_next.mem_en = st_reg.mem_en;
            endcase
        end
        if (wr_ok && hit(i_addr, `DBP_OFS_DRIVE)) begin
            st_next.drive_req = i_wr_data[3:0];
        end

        // Pin outputs; the line drives are all released outside running and in standby
        st_next.drive.pos = 1'b0;
        st_next.drive.neg = 1'b0;
        st_next.drive.k = 1'b0;
        st_next.drive.l = 1'b0;
        if (st_next.state == dbp_pkg::DBP_RUN && !st_next.standby) begin
            st_next.drive.pos = st_next.drive_req[`DBP_DRV_POS];
            st_next.drive.neg = st_next.drive_req[`DBP_DRV_NEG]
                && (st_next.proto == dbp_pkg::DBP_PROTO_PWM);
            st_next.drive.k = st_next.drive_req[`DBP_DRV_K];
            st_next.drive.l = st_next.drive_req[`DBP_DRV_L];
        end
        st_next.supply_sel = (st_next.proto == dbp_pkg::DBP_PROTO_VPW)
            ^ st_next.supply_pol;
        st_next.osc_en = !st_next.standby;
        st_next.baud_sel = baud_of(st_next.baud_strap, st_next.baud_ovr_en);

        // Receive inputs normalised to active high
        st_next.vpw_act = pins[`DBP_PIN_VPW];
        st_next.iso_act = !pins[`DBP_PIN_ISO];
        st_next.pwm_act = !pins[`DBP_PIN_PWM];

        // Register reads, data valid in the following cycle only
        if (i_rd_en) begin
            if (hit(i_addr, `DBP_OFS_CTRL)) begin
                st_next.rd_data[`DBP_CTRL_PROTO_LSB +: 2] = st_reg.proto;
                st_next.rd_data[`DBP_CTRL_SUPPLY_POL] = st_reg.supply_pol;
                st_next.rd_data[`DBP_CTRL_BAUD_OVR_EN] = st_reg.baud_ovr_en;
                st_next.rd_data[`DBP_CTRL_STANDBY] = st_reg.standby;
                st_next.rd_data[`DBP_CTRL_BAUD_OVR_LSB +: 8] = st_reg.baud_ovr;
            end else if (hit(i_addr, `DBP_OFS_DRIVE)) begin
                st_next.rd_data[3:0] = st_reg.drive_req;
            end else if (hit(i_addr, `DBP_OFS_STATUS)) begin
                st_next.rd_data[`DBP_ST_VPW] = st_reg.vpw_act;
                st_next.rd_data[`DBP_ST_ISO] = st_reg.iso_act;
                st_next.rd_data[`DBP_ST_PWM] = st_reg.pwm_act;
                st_next.rd_data[`DBP_ST_MEM] = st_reg.mem_en;
                st_next.rd_data[`DBP_ST_LF] = st_reg.lf_en;
                st_next.rd_data[`DBP_ST_BAUD_LSB +: 2] = st_reg.baud_sel;
                st_next.rd_data[`DBP_ST_RUN] = run;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_reg <= ST_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_rd_data = st_reg.rd_data;
    assign o_bus_supply_select = st_reg.supply_sel;
    assign o_pos_line_drive = st_reg.drive.pos;
    assign o_neg_line_drive = st_reg.drive.neg;
    assign o_k_line_drive = st_reg.drive.k;
    assign o_l_line_drive = st_reg.drive.l;
    assign o_osc_enable = st_reg.osc_en;
    assign o_baud_sel = st_reg.baud_sel;
    assign o_baud_override = st_reg.baud_ovr;
    assign o_mem_enable = st_reg.mem_en;
    assign o_linefeed_enable = st_reg.lf_en;
    assign o_vpw_active = st_reg.vpw_act;
    assign o_iso_active = st_reg.iso_act;
    assign o_pwm_active = st_reg.pwm_act;
    assign o_running = (st_reg.state == dbp_pkg::DBP_RUN);

endmodule : dbp_top

//--- testbench.sv
/*
 * Self-checking bench of dbp_top with the bus transceiver model.
 * Assumes dbp_props.sv and dbp_bus_model.sv are compiled before it.
 */
`timescale 1ns/1ps
`include "dbp_defines.svh"

module testbench;
    logic i_clk, i_rst_b, i_ext_reset_n, i_memory_strap, i_baud_strap, i_line_end_strap;
    logic i_variable_pulse_rx, i_iso_rx_n, i_pulse_width_rx_n, i_wr_en, i_rd_en;
    logic [7:0] i_addr, o_baud_override;
    logic [31:0] i_wr_data, o_rd_data, rdat;
    logic o_bus_supply_select, o_pos_line_drive, o_neg_line_drive, o_k_line_drive;
    logic o_l_line_drive, o_osc_enable, o_mem_enable, o_linefeed_enable, o_running;
    logic o_vpw_active, o_iso_active, o_pwm_active, node_vpw, node_iso, node_pwm;
    dbp_pkg::dbp_baud_t o_baud_sel;
    int num_errors, checks;
    logic [20:0] rows [6];

    dbp_top u_dut (.i_clk, .i_rst_b, .i_ext_reset_n, .i_memory_strap, .i_baud_strap,
        .i_line_end_strap, .i_variable_pulse_rx, .i_iso_rx_n, .i_pulse_width_rx_n, .i_addr,
        .i_wr_data, .i_wr_en, .i_rd_en, .o_rd_data, .o_bus_supply_select, .o_pos_line_drive,
        .o_neg_line_drive, .o_k_line_drive, .o_l_line_drive, .o_osc_enable, .o_baud_sel,
        .o_baud_override, .o_mem_enable, .o_linefeed_enable, .o_vpw_active, .o_iso_active,
        .o_pwm_active, .o_running);
    dbp_bus_model u_bus (.i_pos_drive(o_pos_line_drive), .i_k_drive(o_k_line_drive),
        .i_node_vpw(node_vpw), .i_node_iso(node_iso), .i_node_pwm(node_pwm),
        .o_vpw_rx(i_variable_pulse_rx), .o_iso_rx_n(i_iso_rx_n), .o_pwm_rx_n(i_pulse_width_rx_n));

    always #2.5 i_clk = ~i_clk;

    ////////////////////////////////////////
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr_en <= 1'b0;
        #1;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge i_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd_en <= 1'b0;
        #1;
        rdat = o_rd_data;
    endtask : rd

    task wait_run;
        int i;
        i = 0;
        while (o_running !== 1'b1 && i < 100) begin
            @(negedge i_clk);
            i++;
        end
        chk(o_running, 32'h1);
    endtask : wait_run

    function logic [31:0] cfg;
        return {28'h0, o_mem_enable, o_linefeed_enable, o_baud_sel};
    endfunction : cfg

    task end_sim;
        $display("errors=%0d checks=%0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////
    initial begin
        #50000;
        num_errors++;
        end_sim;
    end

    initial begin
        i_clk = 1'b0;
        i_rst_b = 1'b0;
        i_ext_reset_n = 1'b1;
        {i_memory_strap, i_baud_strap, i_line_end_strap} = 3'h6;
        {i_addr, i_wr_data, i_wr_en, i_rd_en} = '0;
        {node_vpw, node_iso, node_pwm} = 3'h0;
        num_errors = 0;
        checks = 0;
        // Control, drive request, {osc, supply, pos, neg, k, l, vpw, iso, pwm}
        rows = '{{8'h00, 4'hF, 9'h1DF}, {8'h01, 4'hF, 9'h17F}, {8'h02, 4'h6, 9'h112},
                 {8'h05, 4'h2, 9'h1A0}, {8'h04, 4'h9, 9'h14D}, {8'h10, 4'hF, 9'h080}};
        repeat (3) @(negedge i_clk);
        chk({27'h0, o_pos_line_drive, o_neg_line_drive, o_k_line_drive, o_l_line_drive,
            o_running}, 32'h0);
        chk(o_bus_supply_select, 32'h1);
        repeat (3) @(posedge i_clk);
        i_rst_b <= 1'b1;
        wait_run;
        chk(cfg(), {28'h0, 2'h2, dbp_pkg::DBP_BAUD_38400});
        @(posedge i_clk);
        {i_memory_strap, i_baud_strap, i_line_end_strap} <= 3'h1;
        repeat (10) @(negedge i_clk);
        chk(cfg(), {28'h0, 2'h2, dbp_pkg::DBP_BAUD_38400});
        for (int n = 0; n < 6; n++) begin
            wr(`DBP_OFS_CTRL, {24'h0, rows[n][20:13]});
            wr(`DBP_OFS_DRIVE, {28'h0, rows[n][12:9]});
            repeat (5) @(negedge i_clk);
            chk({23'h0, o_osc_enable, o_bus_supply_select, o_pos_line_drive, o_neg_line_drive,
                o_k_line_drive, o_l_line_drive, o_vpw_active, o_iso_active, o_pwm_active},
                {23'h0, rows[n][8:0]});
        end
        wr(`DBP_OFS_CTRL, 32'h0);
        rd(`DBP_OFS_DRIVE);
        chk(rdat, 32'hF);
        wr(`DBP_OFS_DRIVE, 32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(`DBP_OFS_CMD, c);
            chk({30'h0, o_mem_enable, o_linefeed_enable}, (c < 2) ? c * 2 : c);
        end
        rd(`DBP_OFS_STATUS);
        chk(rdat, 32'hB8);
        @(posedge i_clk);
        {node_vpw, node_iso, node_pwm} <= 3'h7;
        repeat (5) @(posedge i_clk);
        rd(`DBP_OFS_STATUS);
        chk(rdat, 32'hBF);
        @(posedge i_clk);
        {node_vpw, node_iso, node_pwm} <= 3'h0;
        rd(8'h10);
        chk(rdat, 32'h0);
        wr(`DBP_OFS_CTRL, 32'h5A08);
        chk({22'h0, o_baud_override, o_baud_sel}, {22'h0, 8'h5A, dbp_pkg::DBP_BAUD_OVERRIDE});
        @(posedge i_clk);
        i_ext_reset_n <= 1'b0;
        repeat (300) @(posedge i_clk);
        i_ext_reset_n <= 1'b1;
        repeat (10) @(negedge i_clk);
        chk(o_running, 32'h1);
        @(posedge i_clk);
        i_ext_reset_n <= 1'b0;
        repeat (450) @(negedge i_clk);
        chk(o_running, 32'h0);
        wr(`DBP_OFS_DRIVE, 32'h1);
        @(posedge i_clk);
        i_ext_reset_n <= 1'b1;
        wait_run;
        chk(cfg(), {28'h0, 2'h1, dbp_pkg::DBP_BAUD_9600});
        chk({23'h0, o_baud_override, o_pos_line_drive}, {23'h0, 8'h5A, 1'b0});
        end_sim;
    end
endmodule : testbench
